// ==== rtl/mil_map.svh ====
// Purpose : offsets, field positions and reset values of the interrupt logic
// Assumes : included by the package and by every design file that needs it
// Notes   : definitions only
`ifndef MIL_MAP_SVH
`define MIL_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets on the serial register port
// ----------------------------------------------------------------------------
`define MIL_ADDR_W          7
`define MIL_OFS_ENABLE      7'h18
`define MIL_OFS_FLAGS       7'h19
`define MIL_OFS_FLAGS_COR   7'h1a

// ----------------------------------------------------------------------------
// widths, reset values and writable bits
// ----------------------------------------------------------------------------
`define MIL_REG_W           24
`define MIL_ENABLE_RST      24'h000000
`define MIL_FLAGS_RST       24'h000000
`define MIL_ENABLE_WMASK    24'h0fdfff
`define MIL_ZERO_WORD       24'h000000

// ----------------------------------------------------------------------------
// flag and enable bit positions
// ----------------------------------------------------------------------------
`define MIL_B_ACTIVE_ENERGY_HALF_FULL          0
`define MIL_B_REACTIVE_ENERGY_HALF_FULL          1
`define MIL_B_APPARENT_ENERGY_HALF_FULL         2
`define MIL_B_SAG           3
`define MIL_B_ZXTO          6
`define MIL_B_ZX            9
`define MIL_B_LINE          12
`define MIL_B_RESET         13
`define MIL_B_PKV           14
`define MIL_B_PKI           15
`define MIL_B_WAVE          16
`define MIL_B_REVP          17
`define MIL_B_REVQ          18
`define MIL_B_SEQ           19
`define MIL_N_PHASE         3
`define MIL_PH_A            0
`define MIL_PH_B            1
`define MIL_PH_C            2

`endif

// ==== rtl/mil_pkg.sv ====
// Purpose : types and shared functions of the interrupt logic
// Assumes : mil_map.svh holds every number
// Notes   : state structs, one per module
`include "mil_map.svh"

package mil_pkg;

   typedef logic [`MIL_REG_W-1:0]   mil_word_t;
   typedef logic [`MIL_N_PHASE-1:0] mil_phase_t;
   typedef logic [`MIL_ADDR_W-1:0]  mil_addr_t;

   // accumulator tap edge detector state
   typedef struct packed {
      mil_phase_t ae_tap;
      mil_phase_t re_tap;
      mil_phase_t va_tap;
      logic       primed;
      logic       boot;
      logic [2:0] energy_evt;
      logic       boot_evt;
   } mil_dec_state_t;

   // sticky flag bank state
   typedef struct packed {
      mil_word_t flags;
   } mil_bank_state_t;

   // sequence tracker
   typedef enum logic [1:0] {
      MIL_SEQ_IDLE,
      MIL_SEQ_AFTER_A
   } mil_seq_t;

   // top level state
   typedef struct packed {
      mil_word_t  enable;
      mil_word_t  rdata;
      logic       rvalid;
      logic       irq_oe;
      logic       irq_n;
      mil_word_t  evt;
      mil_phase_t p_sign;
      mil_phase_t q_sign;
      logic       signs_primed;
      mil_seq_t   seq;
   } mil_top_state_t;

   // any bit that differs between two samples
   function automatic logic any_change(input mil_phase_t now_v,
                                       input mil_phase_t old_v);
      any_change = |(now_v ^ old_v);
   endfunction : any_change

   // any bit that went from low to high
   function automatic logic any_rise(input mil_phase_t now_v,
                                     input mil_phase_t old_v);
      any_rise = |(now_v & ~old_v);
   endfunction : any_rise

endpackage : mil_pkg

// ==== rtl/mil_evt_if.sv ====
// Purpose : carries event strobes, flags and clear between the modules
// Assumes : one clock domain
// Notes   : each signal has one driving modport
`include "mil_map.svh"

interface mil_evt_if;
   logic [2:0]            energy_evt;  // active_energy_half_full, reactive_energy_half_full, apparent_energy_half_full strobes
   logic                  boot_evt;    // one cycle after reset release
   logic [`MIL_REG_W-1:0] evt;         // full event vector, one-cycle
   logic [`MIL_REG_W-1:0] clr;         // clear request, all bits
   logic [`MIL_REG_W-1:0] flags;       // sticky flags

   modport dec  (output energy_evt, output boot_evt);
   modport bank (input evt, input clr, output flags);
   modport top  (input energy_evt, input boot_evt, input flags,
                 output evt, output clr);
endinterface : mil_evt_if

// ==== rtl/mil_tap_detect.sv ====
// Purpose : watches accumulator taps and reports half-full events
// Assumes : taps come from logic on mclk_i
// Notes   : first sample after reset only primes the history
`include "mil_map.svh"

module mil_tap_detect (
   input  wire logic                mclk_i,
   input  wire logic                rst_n_i,
   input  wire mil_pkg::mil_phase_t ae_tap_i,
   input  wire mil_pkg::mil_phase_t re_tap_i,
   input  wire mil_pkg::mil_phase_t va_tap_i,
   mil_evt_if.dec                   ev
);
   import mil_pkg::*;

   mil_dec_state_t s_q;
   mil_dec_state_t s_d;

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   // history is primed first so a tap already high at reset is not an event
   always_comb begin
      s_d            = s_q;
      s_d.ae_tap     = ae_tap_i;
      s_d.re_tap     = re_tap_i;
      s_d.va_tap     = va_tap_i;
      s_d.primed     = 1'b1;
      s_d.boot       = 1'b0;
      s_d.boot_evt   = s_q.boot;
      s_d.energy_evt[0] = s_q.primed & any_change(ae_tap_i, s_q.ae_tap);
      s_d.energy_evt[1] = s_q.primed & any_change(re_tap_i, s_q.re_tap);
      s_d.energy_evt[2] = s_q.primed & any_rise(va_tap_i, s_q.va_tap);
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q      <= '0;
         s_q.boot <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign ev.energy_evt = s_q.energy_evt;
   assign ev.boot_evt   = s_q.boot_evt;

endmodule : mil_tap_detect

// ==== rtl/mil_flag_bank.sv ====
// Purpose : sticky interrupt flags
// Assumes : evt and clr are on mclk_i
// Notes   : a set in the clear cycle wins over the clear
`include "mil_map.svh"

module mil_flag_bank (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   mil_evt_if.bank   ev
);
   import mil_pkg::*;

   mil_bank_state_t s_q;
   mil_bank_state_t s_d;

   // -------------------------------------------------------------------------
   // flag update
   // -------------------------------------------------------------------------
   // flags are set regardless of enables; only the clear request drops them, except the reset bit
   always_comb begin
      s_d       = s_q;
      s_d.flags = (s_q.flags & ~ev.clr) | ev.evt;
      // the reset indication lives for one cycle only
      s_d.flags[`MIL_B_RESET] = ev.evt[`MIL_B_RESET];
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q.flags <= `MIL_FLAGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign ev.flags = s_q.flags;

endmodule : mil_flag_bank

// ==== rtl/mil_irq_top.sv ====
// Purpose : interrupt flags, enables and open-drain request of the meter
// Assumes : event inputs are one-cycle strobes or levels on mclk_i;
//           the serial framing delivers one-cycle read and write strobes
// Notes   : read data appears one cycle after the read strobe
`include "mil_map.svh"

// Notes on behaviour
// - enabled event pulls the request line low
// - clear-on-read status read releases request line
// - every event sets its flag regardless of enable
// - flags stick until clear-on-read read only, except bit 13
// - bit 0: active energy tap 14 changed
// - bit 1: reactive energy tap 14 changed
// - bit 2: apparent energy tap 15 rises
// - bits 3-5: voltage sag per phase
// - bits 6-8: missing crossing per phase
// - bits 9-11: voltage zero crossing per phase
// - bit 12: line cycle accumulation finished
// - bit 14: voltage above peak threshold
// - bit 15: current above peak threshold
// - bit 16: new waveform sample ready
// - bit 17: active power sign flip, selected phases
// - bit 18: reactive power sign flip, selected phases
// - bit 19: crossing A followed by B
// - bit 13: reset indication, one cycle only
module mil_irq_top #(
   parameter int REG_W = `MIL_REG_W
) (
   input  wire logic                mclk_i,
   input  wire logic                reset_n_i,
   // register port from the serial framing
   input  wire mil_pkg::mil_addr_t  reg_addr_i,
   input  wire logic                reg_rd_i,
   input  wire logic                reg_wr_i,
   input  wire mil_pkg::mil_word_t  reg_wdata_i,
   output      mil_pkg::mil_word_t  reg_rdata_o,
   output      logic                reg_rvalid_o,
   // event sources
   input  wire mil_pkg::mil_phase_t active_energy_accum_tap_i,
   input  wire mil_pkg::mil_phase_t reactive_energy_accum_tap_i,
   input  wire mil_pkg::mil_phase_t apparent_energy_accum_tap_i,
   input  wire mil_pkg::mil_phase_t sag_i,
   input  wire mil_pkg::mil_phase_t crossing_timeout_i,
   input  wire mil_pkg::mil_phase_t crossing_i,
   input  wire logic                line_cycle_done_i,
   input  wire logic                peak_voltage_flag_i,
   input  wire logic                peak_current_flag_i,
   input  wire logic                waveform_sample_ready_i,
   input  wire mil_pkg::mil_phase_t active_power_neg_i,
   input  wire mil_pkg::mil_phase_t reactive_power_neg_i,
   input  wire mil_pkg::mil_phase_t phase_sum_select_i,
   // open-drain request line
   output      logic                irq_n_o,
   output      logic                irq_oe_o
);
   import mil_pkg::*;

   // ------------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------------
   // the map is laid out for one fixed word; other widths cannot be served
   if (REG_W != `MIL_REG_W) begin : g_bad_width
      $error("mil_irq_top: REG_W must equal the register word width");
   end

   // ------------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------------
   // assert at once, release after two clean edges so no flop sees a runt
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ------------------------------------------------------------------------
   // sub blocks
   // ------------------------------------------------------------------------
   mil_evt_if ev ();

   mil_tap_detect u_tap (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n),
      .ae_tap_i (active_energy_accum_tap_i),
      .re_tap_i (reactive_energy_accum_tap_i),
      .va_tap_i (apparent_energy_accum_tap_i),
      .ev       (ev)
   );

   mil_flag_bank u_bank (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n),
      .ev      (ev)
   );

   // ------------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------------
   logic rd_enable;
   logic rd_flags;
   logic rd_flags_cor;
   logic wr_enable;

   assign rd_enable    = reg_rd_i & (reg_addr_i == `MIL_OFS_ENABLE);
   assign rd_flags     = reg_rd_i & (reg_addr_i == `MIL_OFS_FLAGS);
   assign rd_flags_cor = reg_rd_i & (reg_addr_i == `MIL_OFS_FLAGS_COR);
   assign wr_enable    = reg_wr_i & (reg_addr_i == `MIL_OFS_ENABLE);

   // only the clear-on-read copy clears; the plain copy leaves flags alone
   assign ev.clr = rd_flags_cor ? ~`MIL_ZERO_WORD : `MIL_ZERO_WORD;

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   mil_top_state_t s_q;
   mil_top_state_t s_d;

   // ------------------------------------------------------------------------
   // event assembly, registers and request line
   // ------------------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // events are registered once so every port source lines up; tap and reset strobes arrive registered and lag a cycle
      s_d.evt = `MIL_ZERO_WORD;
      s_d.evt[`MIL_B_ACTIVE_ENERGY_HALF_FULL]  = ev.energy_evt[0];
      s_d.evt[`MIL_B_REACTIVE_ENERGY_HALF_FULL]  = ev.energy_evt[1];
      s_d.evt[`MIL_B_APPARENT_ENERGY_HALF_FULL] = ev.energy_evt[2];
      s_d.evt[`MIL_B_SAG  +: `MIL_N_PHASE] = sag_i;
      s_d.evt[`MIL_B_ZXTO +: `MIL_N_PHASE] = crossing_timeout_i;
      s_d.evt[`MIL_B_ZX   +: `MIL_N_PHASE] = crossing_i;
      s_d.evt[`MIL_B_LINE]  = line_cycle_done_i;
      s_d.evt[`MIL_B_RESET] = ev.boot_evt;
      s_d.evt[`MIL_B_PKV]   = peak_voltage_flag_i;
      s_d.evt[`MIL_B_PKI]   = peak_current_flag_i;
      s_d.evt[`MIL_B_WAVE]  = waveform_sample_ready_i;

      // sign flips only count on phases in the summation; first sample
      // after reset just loads the history
      s_d.p_sign       = active_power_neg_i;
      s_d.q_sign       = reactive_power_neg_i;
      s_d.signs_primed = 1'b1;
      s_d.evt[`MIL_B_REVP] = s_q.signs_primed &
         any_change(active_power_neg_i & phase_sum_select_i,
                    s_q.p_sign & phase_sum_select_i);
      s_d.evt[`MIL_B_REVQ] = s_q.signs_primed &
         any_change(reactive_power_neg_i & phase_sum_select_i,
                    s_q.q_sign & phase_sum_select_i);

      // phase order: after an A crossing the next crossing must be C
      unique case (s_q.seq)
         MIL_SEQ_IDLE: begin
            if (crossing_i[`MIL_PH_A]) begin
               s_d.seq = MIL_SEQ_AFTER_A;
            end
         end
         MIL_SEQ_AFTER_A: begin
            if (crossing_i[`MIL_PH_B]) begin
               s_d.evt[`MIL_B_SEQ] = 1'b1;
               s_d.seq = MIL_SEQ_IDLE;
            end else if (crossing_i[`MIL_PH_C]) begin
               s_d.seq = MIL_SEQ_IDLE;
            end
         end
         default: begin
            s_d.seq = MIL_SEQ_IDLE;
         end
      endcase
      // a new A crossing restarts the watch
      if (crossing_i[`MIL_PH_A]) begin
         s_d.seq = MIL_SEQ_AFTER_A;
      end

      // enable bits; reserved bit and upper bits stay zero
      if (wr_enable) begin
         s_d.enable = reg_wdata_i & `MIL_ENABLE_WMASK;
      end

      // read data is taken before the clear lands
      s_d.rvalid = reg_rd_i;
      if (rd_enable) begin
         s_d.rdata = s_q.enable;
      end else if (rd_flags | rd_flags_cor) begin
         s_d.rdata = ev.flags;
      end else begin
         s_d.rdata = `MIL_ZERO_WORD;
      end

      // pull low while any enabled flag is set; a clearing read drops
      // the flags and so releases the line a cycle later
      s_d.irq_oe = |(ev.flags & s_q.enable);
      s_d.irq_n  = 1'b0;
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_q        <= '0;
         s_q.enable <= `MIL_ENABLE_RST;
         s_q.seq    <= MIL_SEQ_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign ev.evt = s_q.evt;

   // ------------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------------
   assign reg_rdata_o  = s_q.rdata;
   assign reg_rvalid_o = s_q.rvalid;
   assign irq_n_o      = s_q.irq_n;
   assign irq_oe_o     = s_q.irq_oe;

endmodule : mil_irq_top

// ==== test/mil_irq_properties.sv ====
// Purpose : timing checks on the ports of the interrupt top
// Assumes : enable bits are mirrored from register writes
// Notes   : taps, signs and sequence errors are kept out of timing checks
`include "mil_map.svh"

module mil_irq_properties
   import mil_pkg::*;
(
   input wire logic       mclk_i,
   input wire logic       reset_n_i,
   input wire mil_addr_t  reg_addr_i,
   input wire logic       reg_rd_i,
   input wire logic       reg_wr_i,
   input wire mil_word_t  reg_wdata_i,
   input wire mil_word_t  reg_rdata_o,
   input wire logic       reg_rvalid_o,
   input wire mil_phase_t sag_i,
   input wire mil_phase_t crossing_timeout_i,
   input wire mil_phase_t crossing_i,
   input wire logic       line_cycle_done_i,
   input wire logic       peak_voltage_flag_i,
   input wire logic       peak_current_flag_i,
   input wire logic       waveform_sample_ready_i,
   input wire logic       irq_n_o,
   input wire logic       irq_oe_o
);
   timeunit 1ns;
   timeprecision 100ps;

   mil_word_t en_q;
   mil_word_t evv;
   logic      hit;

   // pulse sources placed at their flag positions
   assign evv = {7'h00, waveform_sample_ready_i, peak_current_flag_i,
                 peak_voltage_flag_i, 1'b0, line_cycle_done_i, crossing_i,
                 crossing_timeout_i, sag_i, 3'h0};
   assign hit = |(evv & en_q);

   // mirror of the enable register, reserved bits read as zero
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_q <= 24'h000000;
      end else if (reg_wr_i && reg_addr_i == 7'h18) begin
         en_q <= reg_wdata_i & 24'h0fdfff;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   read_answer_a: assert property (
      reg_rd_i |=> reg_rvalid_o) else $error("read got no valid pulse");
   answer_pulse_a: assert property (
      !reg_rd_i |=> !reg_rvalid_o) else $error("valid without a read");
   enable_read_a: assert property (
      reg_rd_i && reg_addr_i == 7'h18 |=> reg_rdata_o == en_q)
      else $error("enable readback wrong");
   unmapped_zero_a: assert property (
      reg_rd_i && (reg_addr_i < 7'h18 || reg_addr_i > 7'h1a)
      |=> reg_rdata_o == 24'h000000) else $error("unmapped read not zero");
   irq_rise_a: assert property (
      hit |-> ##3 irq_oe_o) else $error("enabled event left line released");
   clear_release_a: assert property (
      reg_rd_i && reg_addr_i == 7'h1a && (en_q & 24'h0e0007) == 24'h0
      && !$past(hit) |-> ##2 !irq_oe_o)
      else $error("clear read did not release line");
   irq_hold_a: assert property (
      irq_oe_o && !reg_rd_i && !reg_wr_i && !$past(reg_rd_i)
      && !$past(reg_wr_i) |=> irq_oe_o) else $error("line dropped alone");
   irq_quiet_a: assert property (
      en_q == 24'h0 && $past(en_q) == 24'h0 |-> !irq_oe_o)
      else $error("line pulled with all enables off");
   drain_data_a: assert property (
      irq_n_o == 1'b0) else $error("open drain data not low");
endmodule : mil_irq_properties

bind mil_irq_top mil_irq_properties u_props (
   .mclk_i, .reset_n_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i,
   .reg_rdata_o, .reg_rvalid_o, .sag_i, .crossing_timeout_i, .crossing_i,
   .line_cycle_done_i, .peak_voltage_flag_i, .peak_current_flag_i,
   .waveform_sample_ready_i, .irq_n_o, .irq_oe_o);

// ==== test/mil_host.sv ====
// Purpose : host model on the register port of the interrupt logic
// Assumes : strobes move 1 ns after the rising edge
// Notes   : released lines carry inverted values, never the last ones
module mil_host
   import mil_pkg::*;
(
   input  wire logic      mclk_i,
   output mil_addr_t      reg_addr_o,
   output logic           reg_rd_o,
   output logic           reg_wr_o,
   output mil_word_t      reg_wdata_o,
   input  wire mil_word_t reg_rdata_i,
   input  wire logic      reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle port at time zero
   initial begin
      reg_addr_o  = 7'h00;
      reg_rd_o    = 1'b0;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 24'h000000;
   end

   task automatic wr(input mil_addr_t a, input mil_word_t d);
      @(posedge mclk_i);
      #1;
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'b1;
      @(posedge mclk_i);
      #1;
      reg_wr_o    = 1'b0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask : wr

   // answer is due one cycle after the strobe; four are allowed
   task automatic rd(input mil_addr_t a, output mil_word_t d,
                     output bit ok);
      ok = 1'b0;
      d  = 24'h000000;
      @(posedge mclk_i);
      #1;
      reg_addr_o = a;
      reg_rd_o   = 1'b1;
      @(posedge mclk_i);
      #1;
      reg_rd_o   = 1'b0;
      reg_addr_o = ~a;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (reg_rvalid_i === 1'b1) begin
            d  = reg_rdata_i;
            ok = 1'b1;
         end else begin
            @(posedge mclk_i);
            #1;
         end
      end
   endtask : rd

   // service: plain status first to find the source, then clear
   task automatic service(output mil_word_t st, output mil_word_t cl,
                          output bit ok);
      bit ok2;
      rd(7'h19, st, ok);
      rd(7'h1a, cl, ok2);
      ok = ok & ok2;
   endtask : service
endmodule : mil_host

// ==== test/metering_interrupt_logic_tb.sv ====
// Purpose : self-checking bench of the interrupt logic
// Assumes : open-drain request line has a pull-up
// Notes   : sign-flip watch covers phase a only
module metering_interrupt_logic_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mil_pkg::*;

   logic       mclk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   mil_addr_t  reg_addr;
   logic       reg_rd, reg_wr, reg_rvalid, irq_n, irq_oe;
   mil_word_t  reg_wdata, reg_rdata;
   mil_word_t  ev_v = 24'h000000;
   mil_phase_t ae_tap = 3'h0, re_tap = 3'h0, va_tap = 3'h0;
   mil_phase_t p_neg = 3'h0, q_neg = 3'h0, sum_sel = 3'h1;
   // pull-up model: the driven level is the design's own open-drain data
   wire        irq_wire = irq_oe ? irq_n : 1'b1;
   int         failures = 0, tests_run = 0;

   // free running 250 MHz clock
   initial begin
      forever #2 mclk_i = ~mclk_i;
   end

   mil_host u_host (.mclk_i, .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
      .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
      .reg_rvalid_i(reg_rvalid));

   mil_irq_top u_dut (.mclk_i, .reset_n_i, .reg_addr_i(reg_addr),
      .reg_rd_i(reg_rd), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
      .active_energy_accum_tap_i(ae_tap), .reactive_energy_accum_tap_i(re_tap),
      .apparent_energy_accum_tap_i(va_tap), .sag_i(ev_v[5:3]),
      .crossing_timeout_i(ev_v[8:6]), .crossing_i(ev_v[11:9]),
      .line_cycle_done_i(ev_v[12]), .peak_voltage_flag_i(ev_v[14]),
      .peak_current_flag_i(ev_v[15]), .waveform_sample_ready_i(ev_v[16]),
      .active_power_neg_i(p_neg), .reactive_power_neg_i(q_neg),
      .phase_sum_select_i(sum_sel), .irq_n_o(irq_n), .irq_oe_o(irq_oe));

   task automatic check(input mil_word_t seen, input mil_word_t exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   // a missing answer ends the run at once
   task automatic rdc(input mil_addr_t a, input mil_word_t e);
      mil_word_t d;
      bit        ok;
      u_host.rd(a, d, ok);
      if (!ok) begin
         failures++;
         test_done();
      end else begin
         check(d, e);
      end
   endtask : rdc

   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : step

   task automatic pulse(input int b);
      ev_v = 24'h000001 << b;
      step(1);
      ev_v = 24'h000000;
      step(4);
   endtask : pulse

   task automatic t_regs;
      u_host.wr(7'h18, 24'hffffff);
      rdc(7'h18, 24'h0fdfff);
      u_host.wr(7'h19, 24'hffffff);
      rdc(7'h19, 24'h000000);
      rdc(7'h7f, 24'h000000);
      u_host.wr(7'h18, 24'h000000);
   endtask : t_regs

   // every pulse source except the A and B crossings, with its enable off
   task automatic t_sources;
      for (int b = 3; b < 17; b++) begin
         if (b != 9 && b != 10 && b != 13) begin
            pulse(b);
            rdc(7'h19, 24'h000001 << b);
            check({23'h0, irq_wire}, 24'h000001);
            rdc(7'h19, 24'h000001 << b);
            rdc(7'h1a, 24'h000001 << b);
            rdc(7'h19, 24'h000000);
         end
      end
   endtask : t_sources

   // a-c-b is a good order, a-b is not
   task automatic t_seq;
      pulse(9);
      pulse(11);
      pulse(10);
      rdc(7'h1a, 24'h000e00);
      pulse(9);
      pulse(10);
      rdc(7'h1a, 24'h080600);
   endtask : t_seq

   task automatic t_irq;
      mil_word_t st;
      mil_word_t cl;
      bit        ok;
      u_host.wr(7'h18, 24'h000008);
      pulse(4);
      check({23'h0, irq_wire}, 24'h000001);
      pulse(3);
      check({23'h0, irq_wire}, 24'h000000);
      u_host.service(st, cl, ok);
      check({23'h0, ok}, 24'h000001);
      check(st, 24'h000018);
      check(cl, 24'h000018);
      step(2);
      check({23'h0, irq_wire}, 24'h000001);
      u_host.wr(7'h18, 24'h000000);
   endtask : t_irq

   // both edges of the active bit 14 tap, the rise of the reactive one, only the rise of the bit 15 taps
   task automatic t_taps;
      ae_tap = 3'h2;
      step(6);
      rdc(7'h1a, 24'h000001);
      ae_tap = 3'h0;
      step(6);
      rdc(7'h1a, 24'h000001);
      re_tap = 3'h4;
      step(6);
      rdc(7'h1a, 24'h000002);
      va_tap = 3'h1;
      step(6);
      rdc(7'h1a, 24'h000004);
      va_tap = 3'h0;
      step(6);
      rdc(7'h1a, 24'h000000);
   endtask : t_taps

   // flips on an unselected phase stay silent
   task automatic t_signs;
      p_neg = 3'h2;
      step(6);
      rdc(7'h1a, 24'h000000);
      p_neg = 3'h3;
      step(6);
      rdc(7'h1a, 24'h020000);
      q_neg = 3'h1;
      step(6);
      rdc(7'h1a, 24'h040000);
   endtask : t_signs

   // main sequence, reset held for four cycles
   initial begin
      repeat (4) @(posedge mclk_i);
      #1;
      reset_n_i = 1'b1;
      // the reset flag stands only in the fourth cycle after the
      // synchronised release, so the first read must land on that edge
      repeat (4) @(posedge mclk_i);
      rdc(7'h19, 24'h002000);
      rdc(7'h19, 24'h000000);
      rdc(7'h18, 24'h000000);
      t_regs();
      t_sources();
      t_seq();
      t_irq();
      t_taps();
      t_signs();
      test_done();
   end
endmodule : metering_interrupt_logic_tb
